// *** pkg/aop_regs.vh ***
`ifndef AOP_REGS_VH
`define AOP_REGS_VH

// --------------------------------------------------------------
// bus map (byte addresses, one aligned word each)
// --------------------------------------------------------------
`define AOP_ADDR_MSG 8'h00
`define AOP_ADDR_CTRL 8'h04
`define AOP_ADDR_STAT 8'h08
`define AOP_ADDR_CFG0 8'h0C
`define AOP_ADDR_CFG1 8'h10
`define AOP_ADDR_CFG2 8'h14
`define AOP_ADDR_CFG3 8'h18
`define AOP_RESP_OKAY 2'h0
`define AOP_RESP_SLVERR 2'h2

// --------------------------------------------------------------
// control and status bits
// --------------------------------------------------------------
`define AOP_CTRL_EN 0
`define AOP_CTRL_SOFT 1
`define AOP_CTRL_RESTART 2
`define AOP_CTRL_MCLK_IN 3
`define AOP_CTRL_SCLK_DRV 4
`define AOP_CTRL_LRCLK_DRV 5
`define AOP_CTRL_COMPR 6
`define AOP_CTRL_FMT_LO 8
`define AOP_CTRL_FMT_HI 10
`define AOP_CTRL_RST 11'h000
`define AOP_FMT_MC6_20 3'h1
`define AOP_FMT_MC4_24 3'h2
`define AOP_FMT_MC6_24 3'h3
`define AOP_STAT_RATE_ERR 0
`define AOP_STAT_RATIO_ERR 1
`define AOP_STAT_BUSY 2
`define AOP_STAT_CLEARED 3

// --------------------------------------------------------------
// configuration messages
// --------------------------------------------------------------
`define AOP_PFX_AND 16'h8002
`define AOP_PFX_OR 16'h8001
`define AOP_CFG_BASE 8'h7C
`define AOP_CFG_WORDS 4
`define AOP_CFG_CLK_IDX 3
`define AOP_CFG_RST 24'h000000
`define AOP_CFG_CLK_RST 24'h000100
`define AOP_MCLK_LO 11
`define AOP_MCLK_HI 12
`define AOP_SCLK_LO 8
`define AOP_SCLK_HI 10
`define AOP_POL_BIT 19
`define AOP_MCLK_256 2'h0
`define AOP_MCLK_512 2'h2
`define AOP_MCLK_128 2'h3
`define AOP_MCLK_384 2'h1
`define AOP_SCLK_64A 3'h0
`define AOP_SCLK_64 3'h1
`define AOP_SCLK_128 3'h2
`define AOP_SCLK_256 3'h3
`define AOP_BITS_64 7'h20
`define AOP_BITS_128 7'h40
`define AOP_BITS_256 7'h7F
`define AOP_SAMPLE_W 24

`endif

// *** design/aop_msg_parser.v ***
`timescale 1ns/1ps
`include "aop_regs.vh"

module aop_msg_parser
(
	input wire clk,
	input wire reset,
	input wire restore,
	input wire [23:0] word,
	input wire word_valid,
	output wire [95:0] cfg_bank,
	output reg busy
);

// --------------------------------------------------------------
// command capture
// --------------------------------------------------------------
reg op_and;
reg [7:0] op_addr;
wire is_and = (word[23:8] == `AOP_PFX_AND);
wire is_or = (word[23:8] == `AOP_PFX_OR);
wire [7:0] rel_addr = op_addr - `AOP_CFG_BASE;

// prefix then operand; unknown prefixes are dropped
always @(posedge clk)
begin
	if (reset || restore)
	begin
		busy <= 1'b0;
		op_and <= 1'b0;
		op_addr <= 8'h00;
	end
	else if (word_valid)
	begin
		if (busy)
			busy <= 1'b0;
		else if (is_and || is_or)
		begin
			busy <= 1'b1;
			op_and <= is_and;
			op_addr <= word[7:0];
		end
	end
end

// --------------------------------------------------------------
// configuration words, one per entry
// --------------------------------------------------------------
genvar gi;
generate
	for (gi = 0; gi < `AOP_CFG_WORDS; gi = gi + 1)
	begin : g_cfg
		reg [23:0] value;
		wire hit = busy && word_valid && (rel_addr == gi);
		// one operand per word keeps mask and set strictly in arrival order
		always @(posedge clk)
		begin
			if (reset || restore)
				value <= (gi == `AOP_CFG_CLK_IDX) ? `AOP_CFG_CLK_RST : `AOP_CFG_RST;
			else if (hit)
				value <= op_and ? (value & word) : (value | word);
		end
		assign cfg_bank[gi*24 +: 24] = value;
	end
endgenerate

endmodule // aop_msg_parser

// *** design/aop_clk_cfg.v ***
// Function
// - mclk ratio codes 256,512,128,384 Fs via mask FFE7FF then set bits
// - bit clock codes 64,128,256 Fs via mask FFF8FF then set bits
// - polarity 0: data launched on falling bit clock edge
// - polarity 1: data launched on rising bit clock edge
// - every output sample carries 24 bits
// - input fifo cleared on restart, soft reset and hard reset
// - compressed input realigns on stream sync words, no fifo reset
// - parameters without a message group keep their default value
// - driven bit clock divided from mclk; input bit clock independent
// - driven frame clock divided from mclk; input frame clock independent
// - pcm outputs stay low until software enables them
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "aop_regs.vh"

module aop_clk_cfg
(
	input wire clk,
	input wire reset,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire sclk_in,
	output reg sclk_out,
	output reg sclk_oe,
	input wire lrclk_in,
	output reg lrclk_out,
	output reg lrclk_oe,
	input wire [23:0] sample_data,
	output reg sample_take,
	input wire sync_found,
	output reg pcm_out_zero,
	output reg fifo_clear
);

// --------------------------------------------------------------
// register bus
// --------------------------------------------------------------
reg [7:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;
reg [10:0] ctrl;
reg soft_pulse;
reg restart_pulse;
reg cleared;
reg rate_err;
reg ratio_err;
reg [23:0] msg_word;
reg msg_valid;
wire [95:0] cfg_bank;
wire parser_busy;
wire do_write = aw_held && w_held && !s_axi_bvalid;
wire wr_any = do_write && (w_strb != 4'h0);
wire [23:0] clk_word = cfg_bank[`AOP_CFG_CLK_IDX*24 +: 24];
wire fifo_clear_evt = soft_pulse || restart_pulse;

// write path: address and data taken in either order
always @(posedge clk)
begin
	if (reset)
	begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `AOP_RESP_OKAY;
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_addr <= 8'h00;
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
	end
	else
	begin
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_addr <= s_axi_awaddr;
			aw_held <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
			w_held <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr <= `AOP_ADDR_CFG3 && aw_addr[1:0] == 2'h0)
				? `AOP_RESP_OKAY : `AOP_RESP_SLVERR;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

// register effects; soft and restart bits are one-cycle pulses
always @(posedge clk)
begin
	if (reset)
	begin
		ctrl <= `AOP_CTRL_RST;
		soft_pulse <= 1'b0;
		restart_pulse <= 1'b0;
		msg_word <= 24'h000000;
		msg_valid <= 1'b0;
		cleared <= 1'b0;
	end
	else
	begin
		soft_pulse <= wr_any && aw_addr == `AOP_ADDR_CTRL && w_data[`AOP_CTRL_SOFT];
		restart_pulse <= wr_any && aw_addr == `AOP_ADDR_CTRL && w_data[`AOP_CTRL_RESTART];
		msg_valid <= wr_any && aw_addr == `AOP_ADDR_MSG;
		if (wr_any && aw_addr == `AOP_ADDR_MSG)
			msg_word <= w_data[23:0];
		if (wr_any && aw_addr == `AOP_ADDR_CTRL)
			ctrl <= w_data[10:0] & ~(11'h006);
		// a new clear beats a software acknowledge
		if (fifo_clear_evt)
			cleared <= 1'b1;
		else if (wr_any && aw_addr == `AOP_ADDR_STAT && w_data[`AOP_STAT_CLEARED])
			cleared <= 1'b0;
	end
end

// read path, one word per access
always @(posedge clk)
begin
	if (reset)
	begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `AOP_RESP_OKAY;
	end
	else if (s_axi_arvalid && s_axi_arready)
	begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b1;
		s_axi_rresp <= `AOP_RESP_OKAY;
		case (s_axi_araddr)
			`AOP_ADDR_MSG: s_axi_rdata <= {8'h00, msg_word};
			`AOP_ADDR_CTRL: s_axi_rdata <= {21'h000000, ctrl};
			`AOP_ADDR_STAT: s_axi_rdata <= {28'h0000000, cleared, parser_busy, ratio_err, rate_err};
			`AOP_ADDR_CFG0: s_axi_rdata <= {8'h00, cfg_bank[23:0]};
			`AOP_ADDR_CFG1: s_axi_rdata <= {8'h00, cfg_bank[47:24]};
			`AOP_ADDR_CFG2: s_axi_rdata <= {8'h00, cfg_bank[71:48]};
			`AOP_ADDR_CFG3: s_axi_rdata <= {8'h00, cfg_bank[95:72]};
			default:
			begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `AOP_RESP_SLVERR;
			end
		endcase
	end
	else if (s_axi_rvalid && s_axi_rready)
	begin
		s_axi_rvalid <= 1'b0;
		s_axi_arready <= 1'b1;
	end
end

// soft reset restores the parser state and config word defaults (ctrl keeps its value) so the next message starts clean
aop_msg_parser u_parser
(
	.clk(clk),
	.reset(reset),
	.restore(soft_pulse),
	.word(msg_word),
	.word_valid(msg_valid),
	.cfg_bank(cfg_bank),
	.busy(parser_busy)
);

// --------------------------------------------------------------
// clock ratio decode and checks
// --------------------------------------------------------------
wire [1:0] mclk_code = clk_word[`AOP_MCLK_HI:`AOP_MCLK_LO];
wire [2:0] sclk_code = clk_word[`AOP_SCLK_HI:`AOP_SCLK_LO];
wire [2:0] fmt = ctrl[`AOP_CTRL_FMT_HI:`AOP_CTRL_FMT_LO];
wire pol_rise = clk_word[`AOP_POL_BIT];
wire sclk_is64 = (sclk_code == `AOP_SCLK_64) || (sclk_code == `AOP_SCLK_64A);
reg [3:0] half_div;
reg [6:0] bits_per_ch;

// mclk cycles per half bit clock; zero marks a ratio that cannot divide
always @*
begin
	half_div = 4'h0;
	bits_per_ch = `AOP_BITS_64;
	if (sclk_code == `AOP_SCLK_128)
		bits_per_ch = `AOP_BITS_128;
	else if (sclk_code == `AOP_SCLK_256)
		bits_per_ch = `AOP_BITS_256;
	case (mclk_code)
		`AOP_MCLK_128: half_div = sclk_is64 ? 4'h1 : 4'h0;
		`AOP_MCLK_256: half_div = sclk_is64 ? 4'h2 : (sclk_code == `AOP_SCLK_128) ? 4'h1 : 4'h0;
		`AOP_MCLK_512: half_div = sclk_is64 ? 4'h4 : (sclk_code == `AOP_SCLK_128) ? 4'h2 : 4'h1;
		`AOP_MCLK_384: half_div = sclk_is64 ? 4'h3 : 4'h0;
		default: half_div = 4'h0;
	endcase
end

// status flags flag a configuration the host should not have chosen
always @(posedge clk)
begin
	if (reset)
	begin
		rate_err <= 1'b0;
		ratio_err <= 1'b0;
	end
	else
	begin
		rate_err <= ((fmt == `AOP_FMT_MC6_20) && sclk_is64)
			|| ((fmt == `AOP_FMT_MC4_24) && sclk_is64)
			|| ((fmt == `AOP_FMT_MC6_24) && (sclk_code != `AOP_SCLK_256));
		ratio_err <= (ctrl[`AOP_CTRL_SCLK_DRV] && half_div == 4'h0)
			|| (mclk_code == `AOP_MCLK_384 && !ctrl[`AOP_CTRL_MCLK_IN]);
	end
end

// --------------------------------------------------------------
// bit and frame clocks
// --------------------------------------------------------------
reg sclk_s1;
reg sclk_s2;
reg sclk_s3;
reg lr_s1;
reg lr_s2;
reg [3:0] div_cnt;
reg sclk_int;
reg lr_seen;
reg [6:0] bit_cnt;
reg [22:0] shreg;
wire drive_sclk = ctrl[`AOP_CTRL_SCLK_DRV] && half_div != 4'h0;
wire div_tick = drive_sclk && (div_cnt == half_div - 4'h1);
wire m_rise = div_tick && !sclk_int;
wire m_fall = div_tick && sclk_int;
// input clocks only looked at after the second stage
wire s_rise = sclk_s2 && !sclk_s3;
wire s_fall = !sclk_s2 && sclk_s3;
wire rise = drive_sclk ? m_rise : s_rise;
wire fall = drive_sclk ? m_fall : s_fall;
wire launch = pol_rise ? rise : fall;
wire lr_now = ctrl[`AOP_CTRL_LRCLK_DRV] ? lrclk_out : lr_s2;
wire m_wrap = bit_cnt == bits_per_ch - 7'h01;
wire lr_toggle = launch && ctrl[`AOP_CTRL_LRCLK_DRV] && m_wrap;
wire ch_start = ctrl[`AOP_CTRL_LRCLK_DRV] ? lr_toggle : (launch && lr_now != lr_seen);
wire realign = ctrl[`AOP_CTRL_COMPR] && sync_found;

// synchronisers and divider
always @(posedge clk)
begin
	if (reset)
	begin
		sclk_s1 <= 1'b0;
		sclk_s2 <= 1'b0;
		sclk_s3 <= 1'b0;
		lr_s1 <= 1'b0;
		lr_s2 <= 1'b0;
		div_cnt <= 4'h0;
		sclk_int <= 1'b0;
	end
	else
	begin
		sclk_s1 <= sclk_in;
		sclk_s2 <= sclk_s1;
		sclk_s3 <= sclk_s2;
		lr_s1 <= lrclk_in;
		lr_s2 <= lr_s1;
		if (!drive_sclk || div_tick)
			div_cnt <= 4'h0;
		else
			div_cnt <= div_cnt + 4'h1;
		if (div_tick)
			sclk_int <= !sclk_int;
	end
end

// frame clock, bit counter and output shifter
always @(posedge clk)
begin
	if (reset)
	begin
		sclk_out <= 1'b0;
		sclk_oe <= 1'b0;
		lrclk_out <= 1'b0;
		lrclk_oe <= 1'b0;
		lr_seen <= 1'b0;
		bit_cnt <= 7'h00;
		shreg <= 23'h000000;
		sample_take <= 1'b0;
		pcm_out_zero <= 1'b0;
	end
	else
	begin
		sclk_out <= div_tick ? !sclk_int : sclk_int;
		sclk_oe <= drive_sclk;
		lrclk_oe <= ctrl[`AOP_CTRL_LRCLK_DRV] && drive_sclk;
		sample_take <= ch_start;
		if (lr_toggle)
			lrclk_out <= !lrclk_out;
		if (launch)
			lr_seen <= lr_now;
		if (realign)
			bit_cnt <= 7'h00;
		else if (launch)
			bit_cnt <= (m_wrap || ch_start) ? 7'h00 : bit_cnt + 7'h01;
		if (!ctrl[`AOP_CTRL_EN])
			pcm_out_zero <= 1'b0;
		else if (ch_start)
		begin
			pcm_out_zero <= sample_data[`AOP_SAMPLE_W-1];
			shreg <= sample_data[`AOP_SAMPLE_W-2:0];
		end
		else if (launch)
		begin
			pcm_out_zero <= shreg[22];
			shreg <= {shreg[21:0], 1'b0};
		end
	end
end

// fifo clear: high through hard reset, one pulse on soft reset or restart
always @(posedge clk)
begin
	if (reset)
		fifo_clear <= 1'b1;
	else
		fifo_clear <= fifo_clear_evt;
end

endmodule // aop_clk_cfg

// *** testbench/aop_clk_cfg_chk.sv ***
`timescale 1ns/1ps
// ----
// port checks
// ----
module aop_chk
(
	input wire clk,
	input wire reset,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire sclk_oe,
	input wire lrclk_oe,
	input wire sample_take,
	input wire pcm_out_zero,
	input wire fifo_clear
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// write address and write data both taken at one edge
	wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	AST_FIFO_HARD: assert property ($fell(reset) |-> fifo_clear)
		else $error("fifo clear not held through reset");
	AST_FIFO_PULSE: assert property (fifo_clear |=> !fifo_clear)
		else $error("fifo clear longer than one cycle");
	AST_SOFT_CLR: assert property (wr_go && s_axi_awaddr == 8'h04 && s_axi_wdata[2:1] != 2'h0
		|-> ##3 fifo_clear)
		else $error("no fifo clear after soft reset or restart");
	AST_PCM_IDLE: assert property ($fell(reset) |-> !pcm_out_zero && !sclk_oe && !lrclk_oe)
		else $error("outputs active out of reset");
	AST_TAKE_PULSE: assert property (sample_take |=> !sample_take)
		else $error("sample take not a pulse");
	AST_B_TIME: assert property (wr_go |-> ##2 s_axi_bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_B_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	AST_R_TIME: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	COV_CLR: cover property (!reset && fifo_clear);
	COV_TAKE: cover property (sample_take);
	COV_READ: cover property (s_axi_rvalid && s_axi_rready);
endmodule // aop_chk

// *** testbench/aop_conv_model.sv ***
`timescale 1ns/1ps
// ----
// converter receiving the serial samples
// ----
module aop_conv_model
(
	input wire clk,
	input wire fall,
	input wire sclk,
	input wire lrclk,
	input wire data,
	output logic [23:0] word,
	output int nwords
);
	logic s_d = 1'h0;
	logic lr_d = 1'h0;
	logic [23:0] sh = 24'h0;
	int cnt = 0;
	initial nwords = 0;
	// sample on the valid edge only; frame edge restarts the count
	always @(posedge clk)
	begin
		s_d <= sclk;
		if (sclk !== s_d && sclk === ~fall)
		begin
			cnt = (lrclk !== lr_d) ? 1 : cnt + 1;
			lr_d <= lrclk;
			sh = {sh[22:0], data};
			if (cnt == 24)
			begin
				word <= sh;
				nwords <= nwords + 1;
			end
		end
	end
endmodule // aop_conv_model

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`include "aop_regs.vh"
module tb_top;
	logic clk = 1'h0, reset = 1'h1, fall = 1'h0, pcm_hi = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic sclk_in = 1'h0, lrclk_in = 1'h0, sync_found = 1'h0;
	logic [23:0] sample_data = 24'hA5C3F1, cap_word;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic sclk_out, sclk_oe, lrclk_out, lrclk_oe, sample_take, pcm_out_zero, fifo_clear;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	int n_errors = 0, n_checks = 0, n_clr = 0, cyc = 0, n_words, c;
	aop_clk_cfg aop_clk_cfg_inst (.*);
	aop_conv_model aop_conv_model_inst (.clk(clk), .fall(fall), .sclk(sclk_out),
		.lrclk(lrclk_out), .data(pcm_out_zero), .word(cap_word), .nwords(n_words));
	always #5 clk = ~clk;
	// ----
	// monitors and hang guard
	// ----
	always @(posedge clk)
	begin
		cyc++;
		if (fifo_clear && !reset) n_clr++;
		if (pcm_out_zero) pcm_hi = 1'h1;
		if (cyc == 20000)
		begin
			n_errors++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// ----
	// bus master; holds each request until its ready edge
	// ----
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		rdata = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	// mask then set on the clock word; zero skips a step
	task automatic msg(input logic [23:0] m, input logic [23:0] s);
		if (m != 24'h0) wr(`AOP_ADDR_MSG, 32'h0080027F);
		if (m != 24'h0) wr(`AOP_ADDR_MSG, {8'h00, m});
		if (s != 24'h0) wr(`AOP_ADDR_MSG, 32'h0080017F);
		if (s != 24'h0) wr(`AOP_ADDR_MSG, {8'h00, s});
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_map();
		rd(`AOP_ADDR_CFG3);
		chk("cfg3 default", 32'h00000100, rdata);
		rd(`AOP_ADDR_CFG0);
		chk("cfg0 default", 32'h0, rdata);
		rd(8'h40);
		chk("unmapped rresp", 32'h2, {30'h0, resp});
		wr(8'h40, 32'h1);
		chk("unmapped bresp", 32'h2, {30'h0, resp});
		wr(`AOP_ADDR_CFG3, 32'h00FFFFFF);
		rd(`AOP_ADDR_CFG3);
		chk("cfg3 read only", 32'h00000100, rdata);
		$display("done map");
	endtask
	task automatic t_codes();
		logic [23:0] ms [4] = '{24'h0, 24'h001000, 24'h001800, 24'h000800};
		logic [23:0] ss [3] = '{24'h000100, 24'h000200, 24'h000300};
		for (int i = 0; i < 4; i++)
		begin
			msg(24'hFFE7FF, ms[i]);
			rd(`AOP_ADDR_CFG3);
			chk("mclk code", {8'h00, ms[i] | 24'h000100}, rdata);
		end
		for (int i = 0; i < 3; i++)
		begin
			msg(24'hFFF8FF, ss[i]);
			rd(`AOP_ADDR_CFG3);
			chk("sclk code", {8'h00, ss[i] | 24'h000800}, rdata);
		end
		msg(24'hFFE7FF, 24'h0);
		msg(24'hFFF8FF, 24'h000100);
		$display("done codes");
	endtask
	task automatic t_rate();
		logic [23:0] ss [3] = '{24'h000100, 24'h000200, 24'h000300};
		for (int j = 0; j < 3; j++)
		begin
			msg(24'hFFF8FF, ss[j]);
			for (int f = 1; f < 4; f++)
			begin
				wr(`AOP_ADDR_CTRL, f << 8);
				rd(`AOP_ADDR_STAT);
				chk("rate error", (f == 3) ? (j < 2) : (j < 1), rdata[0]);
			end
		end
		msg(24'hFFF8FF, 24'h000100);
		wr(`AOP_ADDR_CTRL, 32'h0);
		// 384Fs only with mclk coming in and a 64Fs bit clock
		msg(24'hFFE7FF, 24'h000800);
		wr(`AOP_ADDR_CTRL, 32'h0);
		rd(`AOP_ADDR_STAT);
		chk("ratio mclk out", 32'h1, rdata[1]);
		wr(`AOP_ADDR_CTRL, 32'h18);
		rd(`AOP_ADDR_STAT);
		chk("ratio 384 ok", 32'h0, rdata[1]);
		msg(24'hFFF8FF, 24'h000200);
		rd(`AOP_ADDR_STAT);
		chk("ratio 384 128", 32'h1, rdata[1]);
		msg(24'hFFE7FF, 24'h0);
		msg(24'hFFF8FF, 24'h000100);
		wr(`AOP_ADDR_CTRL, 32'h0);
		$display("done rate");
	endtask
	task automatic t_clear();
		c = n_clr;
		msg(24'h0, 24'h080000);
		wr(`AOP_ADDR_MSG, 32'h0080017F);
		wr(`AOP_ADDR_CTRL, 32'h2);
		wr(`AOP_ADDR_MSG, 32'h00000200);
		rd(`AOP_ADDR_CFG3);
		chk("soft reset cfg3", 32'h00000100, rdata);
		chk("soft clears", c + 1, n_clr);
		rd(`AOP_ADDR_STAT);
		chk("cleared flag", 32'h1, rdata[3]);
		wr(`AOP_ADDR_STAT, 32'h8);
		rd(`AOP_ADDR_STAT);
		chk("cleared flag w1c", 32'h0, rdata[3]);
		wr(`AOP_ADDR_CTRL, 32'h4);
		// the pulse leaves the block one edge after the response
		repeat (2) @(posedge clk);
		chk("restart clears", c + 2, n_clr);
		$display("done clear");
	endtask
	task automatic t_serial();
		logic l;
		wr(`AOP_ADDR_CTRL, 32'h30);
		repeat (300) @(posedge clk);
		chk("pcm low unenabled", 32'h0, pcm_hi);
		chk("sclk driven", 32'h1, sclk_oe);
		chk("lrclk driven", 32'h1, lrclk_oe);
		wr(`AOP_ADDR_CTRL, 32'h31);
		repeat (600) @(posedge clk);
		chk("words seen", 32'h1, n_words > 2);
		chk("sample rising", 32'h00A5C3F1, cap_word);
		msg(24'h0, 24'h080000);
		fall <= 1'h1;
		c = n_words;
		repeat (600) @(posedge clk);
		chk("words after flip", 32'h1, n_words > c + 2);
		chk("sample falling", 32'h00A5C3F1, cap_word);
		// sync word mid channel restarts the 32-bit channel count
		wr(`AOP_ADDR_CTRL, 32'h71);
		l = lrclk_out;
		while (lrclk_out === l) @(posedge clk);
		repeat (40) @(posedge clk);
		sync_found <= 1'h1;
		@(posedge clk);
		sync_found <= 1'h0;
		l = lrclk_out;
		c = 0;
		do
		begin
			@(posedge clk);
			c++;
		end while (lrclk_out === l && c < 400);
		chk("realign frame", 32'h1, c >= 124 && c <= 130);
		$display("done serial");
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		reset <= 1'h0;
		t_map();
		t_codes();
		t_rate();
		t_clear();
		t_serial();
		finish_test();
	end
endmodule // tb_top
bind aop_clk_cfg aop_chk aop_chk_inst (.*);
